// ===== hw/ifc_consts.svh
`ifndef IFC_CONSTS_SVH
`define IFC_CONSTS_SVH

// ==========================================================
// Register map of the interrupt control registers.
// ==========================================================
`define IFC_ADDR_REQ_A 16'hFFE0
`define IFC_ADDR_REQ_B 16'hFFE1
`define IFC_ADDR_REQ_C 16'hFFE2
`define IFC_ADDR_MASK_A 16'hFFE4
`define IFC_ADDR_MASK_B 16'hFFE5
`define IFC_ADDR_MASK_C 16'hFFE6
`define IFC_ADDR_URG_A 16'hFFE8
`define IFC_ADDR_URG_B 16'hFFE9
`define IFC_ADDR_URG_C 16'hFFEA

// ==========================================================
// Reset values and field positions.
// ==========================================================
`define IFC_RST_REQ 8'h00
`define IFC_RST_MASK 8'hFF
`define IFC_RST_URG 8'hFF
`define IFC_NUM_SRC 24
`define IFC_SRC_W 5
`define IFC_BIT_WDT 0
`define IFC_BIT_UNUSED 20
`define IFC_UNUSED_VEC 24'h100000
`define IFC_WDT_VEC 24'h000001

`endif

// ===== hw/ifc_pkg.sv
package ifc_pkg;

    // Register group addressed by the CPU data bus.
    typedef enum logic [1:0] {
        IFC_GRP_NONE,
        IFC_GRP_REQ,
        IFC_GRP_MASK,
        IFC_GRP_URG
    } ifc_grp_t;

    // One bit per source, common index in all three groups.
    typedef logic [23:0] ifc_vec_t;

endpackage

// ===== hw/ifc_pick.sv
`timescale 1ns/1ps

// ==========================================================
// Lowest-index-first picker for a request vector.
// ==========================================================
module ifc_pick #(
    parameter int W = 24,
    parameter int IW = 5
) (
    input wire logic [W-1:0] vec,
    output logic any,
    output logic [IW-1:0] idx
);

    logic [W:0] seen;
    logic [W-1:0] first;

    assign seen[0] = 1'b0;

    // A bit is first when no lower bit is set, so bit order is
    // the fixed default order among equal levels.
    for (genvar i = 0; i < W; i++) begin : g_scan
        assign seen[i+1] = seen[i] | vec[i];
        assign first[i] = vec[i] & ~seen[i];
    end

    assign any = seen[W];

    // Encode the single first bit into its index.
    always_comb begin
        idx = '0;
        for (int j = 0; j < W; j++) begin
            if (first[j]) begin
                idx = idx | IW'(j);
            end
        end
    end

endmodule

// ===== hw/ifc_top.sv
`timescale 1ns/1ps
`include "ifc_consts.svh"

module ifc_top (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [23:0] src_event,
    input wire logic wdt_nmi_mode,
    input wire logic [15:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic bus_wr8,
    input wire logic bus_wr16,
    input wire logic bus_wrbit,
    input wire logic [2:0] bus_bit_sel,
    input wire logic bus_rd,
    output logic [15:0] bus_rdata,
    input wire logic cpu_ack,
    input wire logic psw_wr,
    input wire logic psw_accept,
    input wire logic psw_level,
    output logic int_req,
    output logic [4:0] int_src,
    output logic int_high,
    output logic global_accept_flag,
    output logic in_service_level_flag
);

    // ======================================================
    // State.
    // ======================================================
    ifc_pkg::ifc_vec_t req_flags_ff;
    ifc_pkg::ifc_vec_t nxt_req_flags;
    ifc_pkg::ifc_vec_t mask_flags_ff;
    ifc_pkg::ifc_vec_t nxt_mask_flags;
    ifc_pkg::ifc_vec_t urg_flags_ff;
    ifc_pkg::ifc_vec_t nxt_urg_flags;
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    logic accept_ff;
    logic level_ff;
    logic int_req_ff;
    logic nxt_int_req;
    logic [4:0] int_src_ff;
    logic [4:0] nxt_int_src;
    logic int_high_ff;
    logic nxt_int_high;

    // ======================================================
    // Bus decode.
    // ======================================================
    ifc_pkg::ifc_grp_t wr_grp;
    logic [1:0] wr_lane;
    logic addr_hit;
    ifc_pkg::ifc_vec_t sw_we;
    ifc_pkg::ifc_vec_t sw_wd;
    ifc_pkg::ifc_vec_t we_req;
    ifc_pkg::ifc_vec_t we_mask;
    ifc_pkg::ifc_vec_t we_urg;
    ifc_pkg::ifc_vec_t ack_clr;
    logic ack_ok;

    // ======================================================
    // Selection.
    // ======================================================
    ifc_pkg::ifc_vec_t wdt_excl;
    ifc_pkg::ifc_vec_t eligible;
    ifc_pkg::ifc_vec_t high_req;
    logic any_high;
    logic any_low;
    logic [4:0] idx_high;
    logic [4:0] idx_low;
    ifc_pkg::ifc_vec_t rd_req_view;

    // Address decode: the top twelve bits select the block,
    // bits 3:2 select the group and bits 1:0 the byte lane.
    // consecutive flags
    always_comb begin
        addr_hit = (bus_addr[15:4] == 12'(`IFC_ADDR_REQ_A >> 4))
            && (bus_addr[1:0] != 2'h3);
        wr_lane = bus_addr[1:0];
        wr_grp = ifc_pkg::IFC_GRP_NONE;
        if (addr_hit) begin
            case (bus_addr[3:2])
                2'h0: wr_grp = ifc_pkg::IFC_GRP_REQ;
                2'h1: wr_grp = ifc_pkg::IFC_GRP_MASK;
                2'h2: wr_grp = ifc_pkg::IFC_GRP_URG;
                default: wr_grp = ifc_pkg::IFC_GRP_NONE;
            endcase
        end
    end

    // Write enable and data per source bit. A 16-bit write is
    // only honoured at the first register of a group, since the
    // paired word exists only for the first two registers.
    // bit byte word
    always_comb begin
        sw_we = '0;
        sw_wd = '0;
        if (bus_wr16 && wr_lane == 2'h0) begin
            sw_we = 24'h00FFFF;
            sw_wd = {bus_wdata[7:0], bus_wdata};
        end else if (bus_wr8) begin
            sw_we = 24'h0000FF << {wr_lane, 3'h0};
            sw_wd = {3{bus_wdata[7:0]}};
        end else if (bus_wrbit) begin
            sw_we = 24'h000001 << {wr_lane, bus_bit_sel};
            sw_wd = {24{bus_wdata[0]}};
        end
    end

    // Route the write to one group. In nonmaskable watchdog
    // mode the watchdog flag is closed to software writes.
    // watchdog flag access
    always_comb begin
        we_req = '0;
        we_mask = '0;
        we_urg = '0;
        case (wr_grp)
            ifc_pkg::IFC_GRP_REQ: begin
                we_req = sw_we & ~wdt_excl;
            end
            ifc_pkg::IFC_GRP_MASK: we_mask = sw_we;
            ifc_pkg::IFC_GRP_URG: we_urg = sw_we;
            default: we_req = '0;
        endcase
    end

    // An acknowledge only counts while a request is presented;
    // it then clears the flag of the presented source.
    // ack clears flag
    always_comb begin
        ack_ok = cpu_ack && int_req_ff;
        ack_clr = ack_ok ? (24'h000001 << int_src_ff) : 24'h000000;
    end

    // Next pending flags. The event term is ORed last so that
    // neither an acknowledge nor a software clear in the same
    // cycle can lose a fresh request.
    // event sets flag
    always_comb begin
        nxt_req_flags = (req_flags_ff & ~we_req) | (sw_wd & we_req);
        nxt_req_flags = nxt_req_flags & ~ack_clr;
        nxt_req_flags = nxt_req_flags | src_event;
        nxt_req_flags = nxt_req_flags & ~`IFC_UNUSED_VEC;
    end

    // Next mask and level bits; the reserved bit stays at one
    // even if software forgets to write it so.
    // reserved mask one
    always_comb begin
        nxt_mask_flags = (mask_flags_ff & ~we_mask)
            | (sw_wd & we_mask) | `IFC_UNUSED_VEC;
        nxt_urg_flags = (urg_flags_ff & ~we_urg)
            | (sw_wd & we_urg) | `IFC_UNUSED_VEC;
    end

    // Pending flag registers.
    // flags reset zero
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            req_flags_ff <= {3{`IFC_RST_REQ}};
        end else begin
            req_flags_ff <= nxt_req_flags;
        end
    end

    // Mask registers: every source starts masked.
    // masks reset ones
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mask_flags_ff <= {3{`IFC_RST_MASK}};
        end else begin
            mask_flags_ff <= nxt_mask_flags;
        end
    end

    // Level registers: every source starts at the low level.
    // levels reset ones
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            urg_flags_ff <= {3{`IFC_RST_URG}};
        end else begin
            urg_flags_ff <= nxt_urg_flags;
        end
    end

    // ======================================================
    // Read path.
    // ======================================================
    // The watchdog flag reads as zero while the watchdog is the
    // nonmaskable source; its mask bit simply returns the
    // stored value, which software must not rely on then.
    // flag encoding
    assign rd_req_view = req_flags_ff & ~wdt_excl;

    // Read data holds the addressed byte in bits 7:0 and the
    // next register in bits 15:8, which gives the paired word
    // at the first register of a group. Unmapped reads zero.
    always_comb begin
        nxt_rdata = rdata_ff;
        if (bus_rd) begin
            nxt_rdata = 16'h0000;
            case (wr_grp)
                ifc_pkg::IFC_GRP_REQ:
                    nxt_rdata = 16'(rd_req_view >> {wr_lane, 3'h0});
                ifc_pkg::IFC_GRP_MASK:
                    nxt_rdata = 16'(mask_flags_ff >> {wr_lane, 3'h0});
                ifc_pkg::IFC_GRP_URG:
                    nxt_rdata = 16'(urg_flags_ff >> {wr_lane, 3'h0});
                default: nxt_rdata = 16'h0000;
            endcase
            if (wr_lane == 2'h2) begin
                nxt_rdata[15:8] = 8'h00;
            end
        end
    end

    // Read data register; it holds until the next read.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_ff <= 16'h0000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    // ======================================================
    // Request selection.
    // ======================================================
    // The watchdog takes no part in maskable selection while
    // it drives the nonmaskable path, so its level bit and
    // flag have no effect there.
    // watchdog level only
    assign wdt_excl = wdt_nmi_mode ? `IFC_WDT_VEC : 24'h000000;

    // Bitwise combination works because every group shares
    // one source index per bit position.
    // common bit index
    always_comb begin
        eligible = req_flags_ff & ~mask_flags_ff & ~wdt_excl;
        high_req = eligible & ~urg_flags_ff;
    end

    // Pickers for the high-level set and for the full set; the
    // full set picks only when no high request exists.
    ifc_pick #(
        .W(`IFC_NUM_SRC),
        .IW(`IFC_SRC_W)
    ) u_pick_high (
        .vec(high_req),
        .any(any_high),
        .idx(idx_high)
    );

    ifc_pick #(
        .W(`IFC_NUM_SRC),
        .IW(`IFC_SRC_W)
    ) u_pick_low (
        .vec(eligible),
        .any(any_low),
        .idx(idx_low)
    );

    // Presented request. High level first; a low request is
    // offered only while no high service is in progress. The
    // request drops in the acknowledge cycle, which keeps the
    // CPU from taking the same source twice.
    // eligible and accept
    always_comb begin
        nxt_int_req = 1'b0;
        nxt_int_src = int_src_ff;
        nxt_int_high = int_high_ff;
        if (ack_ok) begin
            nxt_int_req = 1'b0;
        end else if (accept_ff && any_high) begin
            nxt_int_req = 1'b1;
            nxt_int_src = idx_high;
            nxt_int_high = 1'b1;
        end else if (accept_ff && level_ff && any_low) begin
            nxt_int_req = 1'b1;
            nxt_int_src = idx_low;
            nxt_int_high = 1'b0;
        end
    end

    // Presented request registers.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            int_req_ff <= 1'b0;
            int_src_ff <= 5'h00;
            int_high_ff <= 1'b0;
        end else begin
            int_req_ff <= nxt_int_req;
            int_src_ff <= nxt_int_src;
            int_high_ff <= nxt_int_high;
        end
    end

    // Global accept flag: cleared on acknowledge, otherwise
    // loaded by the CPU. Acknowledge wins over a CPU load in
    // the same cycle so a taken interrupt is never reopened.
    // clear accept flag
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            accept_ff <= 1'b0;
        end else if (ack_ok) begin
            accept_ff <= 1'b0;
        end else if (psw_wr) begin
            accept_ff <= psw_accept;
        end
    end

    // In-service level flag: takes the level bit of the taken
    // source; one after reset means nothing is in service.
    // copy level bit
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            level_ff <= 1'b1;
        end else if (ack_ok) begin
            level_ff <= urg_flags_ff[int_src_ff];
        end else if (psw_wr) begin
            level_ff <= psw_level;
        end
    end

    // ======================================================
    // Outputs, all straight from flip-flops.
    // ======================================================
    assign bus_rdata = rdata_ff;
    assign int_req = int_req_ff;
    assign int_src = int_src_ff;
    assign int_high = int_high_ff;
    assign global_accept_flag = accept_ff;
    assign in_service_level_flag = level_ff;

endmodule

// ===== tb/ifc_checker.sv
`timescale 1ns/1ps

// ==========================================================
// Port-level checks of the interrupt control registers.
// ==========================================================
module ifc_checker (
    input logic clk,
    input logic rst_n,
    input logic [23:0] src_event,
    input logic wdt_nmi_mode,
    input logic [15:0] bus_addr,
    input logic [15:0] bus_wdata,
    input logic bus_wr8,
    input logic bus_wr16,
    input logic bus_wrbit,
    input logic [2:0] bus_bit_sel,
    input logic bus_rd,
    input logic [15:0] bus_rdata,
    input logic cpu_ack,
    input logic psw_wr,
    input logic psw_accept,
    input logic psw_level,
    input logic int_req,
    input logic [4:0] int_src,
    input logic int_high,
    input logic global_accept_flag,
    input logic in_service_level_flag
);
    logic mapped;
    logic ack;

    // Address decode and a taken acknowledge, shared by the checks.
    assign mapped = bus_addr[15:4] == 12'hFFE && bus_addr[3:2] != 2'h3
        && bus_addr[1:0] != 2'h3;
    assign ack = cpu_ack && int_req;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    ack_clears_a: assert property (ack |=>
        !int_req && !global_accept_flag)
        else $error("acknowledge left request or accept standing");
    ack_level_a: assert property (ack |=>
        in_service_level_flag == !$past(int_high))
        else $error("level flag not copied from accepted source");
    accept_gate_a: assert property (
        !global_accept_flag [*2] |-> !int_req)
        else $error("request presented while accept is clear");
    high_only_a: assert property (
        !in_service_level_flag [*2] ##0 int_req |-> int_high)
        else $error("low request presented during high service");
    status_load_a: assert property (psw_wr && !ack |=>
        global_accept_flag == $past(psw_accept)
        && in_service_level_flag == $past(psw_level))
        else $error("status load not applied");
    unmapped_rd_a: assert property (bus_rd && !mapped |=>
        bus_rdata == 16'h0000)
        else $error("unmapped read returned data");
    spare_bit_a: assert property (bus_rd && mapped
        && bus_addr[1:0] == 2'h2 |=>
        bus_rdata[4] == ($past(bus_addr[3:2]) != 2'h0))
        else $error("spare bit 4 reads wrong level");
    wdt_hide_a: assert property (bus_rd && wdt_nmi_mode
        && bus_addr == 16'hFFE0 |=> bus_rdata[0] == 1'b0)
        else $error("watchdog flag visible in nonmaskable mode");
    src_range_a: assert property (int_req |->
        int_src < 5'h18 && int_src != 5'h14)
        else $error("presented source index out of range");

    cover property (ack && int_high);
    cover property (ack && !int_high);
    cover property (bus_rd && !mapped);
endmodule

bind ifc_top ifc_checker chk (.*);

// ===== tb/ifc_cpu_model.sv
`timescale 1ns/1ps

// ==========================================================
// Behavioural CPU core that accepts and services requests.
// ==========================================================
module ifc_cpu_model (
    input logic clk,
    input logic rst_n,
    input logic int_req,
    input logic in_service_level_flag,
    input logic [1:0] dly,
    output logic cpu_ack,
    output logic psw_wr,
    output logic psw_accept,
    output logic psw_level
);
    logic boot_ff;
    logic [1:0] wait_ff;
    logic [3:0] svc_ff;

    // Quiet outputs from time zero, before the first falling edge.
    initial begin
        cpu_ack = 1'b0;
        psw_wr = 1'b0;
        psw_accept = 1'b0;
        psw_level = 1'b1;
    end

    // Changes land on the falling edge, so the block samples them settled.
    // A large dly keeps a request waiting, as a long instruction would.
    always @(negedge clk) begin
        cpu_ack <= 1'b0;
        psw_wr <= 1'b0;
        if (!rst_n) begin
            boot_ff <= 1'b1;
            wait_ff <= 2'h0;
            svc_ff <= 4'h0;
        end else if (boot_ff) begin
            boot_ff <= 1'b0;
            psw_wr <= 1'b1;
            psw_accept <= 1'b1;
            psw_level <= 1'b1;
        end else if (int_req && !cpu_ack) begin
            if (wait_ff >= dly) begin
                cpu_ack <= 1'b1;
                wait_ff <= 2'h0;
                svc_ff <= 4'hC;
            end else begin
                wait_ff <= wait_ff + 2'h1;
            end
        end else begin
            wait_ff <= 2'h0;
            if (svc_ff == 4'hB || svc_ff == 4'h1) begin
                psw_wr <= 1'b1;
                psw_accept <= 1'b1;
                psw_level <= (svc_ff == 4'h1) | in_service_level_flag;
            end
            if (svc_ff != 4'h0) begin
                svc_ff <= svc_ff - 4'h1;
            end
        end
    end
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps

// ==========================================================
// Stimulus, result queues and verdict.
// ==========================================================
module tb_top;
    logic clk, rst_n, wdt_nmi_mode, bus_wr8, bus_wr16, bus_wrbit, bus_rd;
    logic cpu_ack, psw_wr, psw_accept, psw_level, int_req, int_high;
    logic gaf, isl;
    logic [23:0] src_event, v;
    logic [15:0] bus_addr, bus_wdata, bus_rdata, w;
    logic [7:0] e8;
    logic [4:0] int_src;
    logic [2:0] bus_bit_sel;
    logic [1:0] dly;
    logic [15:0] q_rd[$];
    logic [5:0] q_ack[$];
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc_n = 0;

    ifc_top DUT (.clk(clk), .rst_n(rst_n), .src_event(src_event),
        .wdt_nmi_mode(wdt_nmi_mode), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr8(bus_wr8), .bus_wr16(bus_wr16),
        .bus_wrbit(bus_wrbit), .bus_bit_sel(bus_bit_sel),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata), .cpu_ack(cpu_ack),
        .psw_wr(psw_wr), .psw_accept(psw_accept), .psw_level(psw_level),
        .int_req(int_req), .int_src(int_src), .int_high(int_high),
        .global_accept_flag(gaf), .in_service_level_flag(isl));
    ifc_cpu_model cpu (.clk(clk), .rst_n(rst_n), .int_req(int_req),
        .in_service_level_flag(isl), .dly(dly), .cpu_ack(cpu_ack),
        .psw_wr(psw_wr), .psw_accept(psw_accept), .psw_level(psw_level));

    // A 20 ns clock; it starts high so inputs settle before a rise.
    initial begin
        clk = 1'b1;
        forever #10 clk = ~clk;
    end

    task automatic cmp_rd(input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %0t exp %h got %h", $time, e, g);
        end
    endtask

    task automatic cmp_ack(input logic [5:0] e, input logic [5:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %0t exp %h got %h", $time, e, g);
        end
    endtask

    // One bus cycle; k is {rd, wrbit, wr16, wr8}, s pulses source events.
    task automatic bus(input logic [3:0] k, input logic [15:0] a,
        input logic [15:0] d, input logic [2:0] b, input logic [23:0] s);
        @(negedge clk);
        {bus_rd, bus_wrbit, bus_wr16, bus_wr8} = k;
        bus_addr = a;
        bus_wdata = d;
        bus_bit_sel = b;
        src_event = s;
        @(negedge clk);
        {bus_rd, bus_wrbit, bus_wr16, bus_wr8} = 4'h0;
        src_event = 24'h000000;
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        q_rd.push_back(e);
        bus(4'h8, a, 16'h0000, 3'h0, 24'h000000);
    endtask

    // Bounded wait until every expected acceptance has been seen.
    task automatic drain;
        for (int i = 0; i < 300 && q_ack.size() > 0; i++) begin
            @(negedge clk);
        end
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Results are taken after the edge's updates; causes are read before.
    always @(posedge clk) begin
        logic r, k;
        logic [5:0] got;
        r = bus_rd;
        k = cpu_ack && int_req;
        got = {int_src, int_high};
        #1;
        if (r) cmp_rd(q_rd.size() > 0 ? q_rd.pop_front() : 16'hDEAD,
            bus_rdata);
        if (k) cmp_ack(q_ack.size() > 0 ? q_ack.pop_front() : 6'h3F,
            got);
    end

    // The run needs well under a thousand cycles; stop a hang at 3000.
    always @(posedge clk) begin
        cyc_n++;
        if (cyc_n == 3000) begin
            n_mismatch++;
            finish_test();
        end
    end

    initial begin
        {rst_n, wdt_nmi_mode, bus_wr8, bus_wr16, bus_wrbit, bus_rd} = 6'h0;
        src_event = 24'h000000;
        bus_addr = 16'h0000;
        bus_wdata = 16'h0000;
        bus_bit_sel = 3'h0;
        dly = 2'h0;
        w = 16'($urandom(16409)) | 16'h0081; // Pending bits 0, 7 stay masked.
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        for (int g = 0; g < 3; g++) begin
            for (int j = 0; j < 3; j++) begin
                e8 = (g == 0) ? 8'h00 : 8'hFF;
                rd(16'hFFE0 + 16'(4 * g + j),
                    {(j == 2) ? 8'h00 : e8, e8});
            end
        end
        rd(16'hFFE3, 16'h0000);
        rd(16'hFFEB, 16'h0000);
        $display("reset values test done");
        v = 24'($urandom) & ~24'h100001;
        bus(4'h0, 16'h0000, 16'h0000, 3'h0, v);
        rd(16'hFFE0, v[15:0]);
        rd(16'hFFE2, {8'h00, v[23:16]});
        bus(4'h2, 16'hFFE0, 16'h0000, 3'h0, 24'h000080);
        rd(16'hFFE0, 16'h0080);
        bus(4'h1, 16'hFFE2, 16'h00FF, 3'h0, 24'h000000);
        rd(16'hFFE2, 16'h00EF);
        bus(4'h1, 16'hFFE6, 16'h00EF, 3'h0, 24'h000000);
        rd(16'hFFE6, 16'h00FF);
        bus(4'h1, 16'hFFEA, 16'h0000, 3'h0, 24'h000000);
        rd(16'hFFEA, 16'h0010);
        bus(4'h2, 16'hFFE4, w, 3'h0, 24'h000000);
        bus(4'h2, 16'hFFE5, 16'h0000, 3'h0, 24'h000000);
        rd(16'hFFE4, w);
        bus(4'h4, 16'hFFE8, 16'h0000, 3'h3, 24'h000000);
        rd(16'hFFE8, 16'hFFF7);
        $display("register access test done");
        wdt_nmi_mode = 1'b1;
        bus(4'h4, 16'hFFE0, 16'h0001, 3'h0, 24'h000001);
        rd(16'hFFE0, 16'h0080);
        wdt_nmi_mode = 1'b0;
        bus(4'h2, 16'hFFE0, 16'h0000, 3'h0, 24'h000000);
        bus(4'h1, 16'hFFE2, 16'h0000, 3'h0, 24'h000000);
        $display("watchdog mode test done");
        bus(4'h2, 16'hFFE4, 16'hFD97, 3'h0, 24'h000000);
        bus(4'h2, 16'hFFE8, 16'hFDFF, 3'h0, 24'h000000);
        dly = 2'($urandom);
        q_ack.push_back({5'h09, 1'b1});
        q_ack.push_back({5'h03, 1'b0});
        bus(4'h0, 16'h0000, 16'h0000, 3'h0, 24'h001208);
        drain();
        dly = 2'h3;
        q_ack.push_back({5'h05, 1'b0});
        q_ack.push_back({5'h06, 1'b0});
        bus(4'h0, 16'h0000, 16'h0000, 3'h0, 24'h000060);
        drain();
        rd(16'hFFE0, 16'h1000);
        cmp_rd(16'(q_ack.size()), 16'h0000);
        $display("acceptance order test done");
        repeat (20) @(negedge clk);
        finish_test();
    end
endmodule
